// ===== src/fswg_pkg.sv
// constants and types shared by the flash status and write-gate block
package fswg_pkg;

  // instruction codes
  localparam logic [7:0] PAGE_PROGRAM_CMD      = 8'h02;
  localparam logic [7:0] QUAD_PAGE_PROGRAM_A   = 8'h32;
  localparam logic [7:0] QUAD_PAGE_PROGRAM_B   = 8'h38;
  localparam logic [7:0] INFO_ROW_PROGRAM_CMD  = 8'h62;
  localparam logic [7:0] SECTOR_ERASE_A        = 8'hd7;
  localparam logic [7:0] SECTOR_ERASE_B        = 8'h20;
  localparam logic [7:0] HALF_BLOCK_ERASE_CMD  = 8'h52;
  localparam logic [7:0] FULL_BLOCK_ERASE_CMD  = 8'hd8;
  localparam logic [7:0] WHOLE_ARRAY_ERASE_A   = 8'hc7;
  localparam logic [7:0] WHOLE_ARRAY_ERASE_B   = 8'h60;
  localparam logic [7:0] STATUS_WRITE_CMD      = 8'h01;
  localparam logic [7:0] FUNCTION_WRITE_CMD    = 8'h42;
  localparam logic [7:0] WRITE_UNLOCK_CMD      = 8'h06;
  localparam logic [7:0] WRITE_RELOCK_CMD      = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD       = 8'h05;

  // status word layout
  localparam int          BUSY_BIT    = 0;
  localparam int          PERMIT_BIT  = 1;
  localparam int          GUARD_LSB   = 2;
  localparam int          GUARD_MSB   = 5;
  localparam int          QUAD_BIT    = 6;
  localparam int          LOCK_BIT    = 7;
  localparam logic [7:0]  STATUS_RST  = 8'h00;

  // frame lengths in serial bits
  localparam logic [5:0]  LEN_OPCODE  = 6'h08;
  localparam logic [5:0]  LEN_REGWR   = 6'h10;
  localparam logic [5:0]  LEN_ADDR    = 6'h20;
  localparam logic [5:0]  LEN_PROG    = 6'h28;
  localparam logic [5:0]  LEN_MAX     = 6'h3f;

  // array geometry: sector 4 KB, half block 32 KB, block 64 KB
  localparam int          ADDR_W      = 24;
  localparam int          SECTOR_LSB  = 12;
  localparam int          HALF_LSB    = 15;
  localparam int          BLOCK_LSB   = 16;

  // busy durations in core clock cycles
  localparam int          TMR_W       = 16;
  localparam int          PROG_CYC    = 40;
  localparam int          ERASE_CYC   = 200;
  localparam int          CHIP_CYC    = 1000;
  localparam int          REG_CYC     = 20;

  typedef enum logic [3:0] {
    OP_NONE, OP_PROG, OP_INFO, OP_SECT, OP_HALF, OP_FULL, OP_CHIP, OP_STAT, OP_FUNC
  } fswg_kind_t;

  typedef struct packed {
    logic                         valid;
    fswg_kind_t                   kind;
    logic [ADDR_W-1:0]            addr;
    logic [ADDR_W-SECTOR_LSB-1:0] sector;
    logic [ADDR_W-HALF_LSB-1:0]   halfBlock;
    logic [ADDR_W-BLOCK_LSB-1:0]  block;
  } fswg_arr_op_t;

endpackage : fswg_pkg

// ===== src/fswg_sync.sv
// two flip-flop level synchroniser with clock enable
`timescale 1ns/1ps
`default_nettype none
module fswg_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic             ce,
  // data
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] meta_q;

  // meta_q feeds only the second stage
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      meta_q <= RST_VAL;
      synced <= RST_VAL;
    end else if (ce) begin
      meta_q <= async;
      synced <= meta_q;
    end
  end

endmodule : fswg_sync
`default_nettype wire

// ===== src/fswg_top.sv
// status word, write-permit latch, instruction gate and array geometry
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - array is uniform 4 KB sectors, smallest erase unit
// - eight sectors form 32 KB block, sixteen form 64 KB block, aligned
// - status bit 0 is read-only busy flag during program, erase, register write
// - gated instructions accepted only while busy is 0; host polls first
// - status bit 1 is write-permit latch, set by unlock instruction
// - relock instruction clears the write-permit latch
// - permit latch clears when any program, erase or register write ends
// - with permit 0 every gated instruction is ignored, nothing changes
// - page program, quad program and info-row program are gated
// - both sector erases, 32 KB and 64 KB block erase are gated
// - both chip erases, status write and function write are gated
// - status bits 2..5 are non-volatile read-write block guard bits
// - status bit 6 is non-volatile quad lane enable
// - status bit 7 is non-volatile status lock flag
// - guard and lock cells change only by status write
// - status read returns the whole 8-bit status word
// - guard and lock start at 0; busy and permit power up 0
// - lock set with guard pin low makes status write ignored while quad enable is 0
// - chip erase ignored while any block guard bit is set
// - quad enable turns guard and pause pins into data lanes 2 and 3; here it only disables guard and pause, lanes stay undriven
module fswg_top
  import fswg_pkg::*;
#(
  parameter int PROG_CYCLES  = PROG_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter int CHIP_CYCLES  = CHIP_CYC,
  parameter int REG_CYCLES   = REG_CYC
) (
  // core clock and reset
  input  wire logic   core_clk,
  input  wire logic   arst_n,
  input  wire logic   clkEn,
  // serial link
  input  wire logic   sclk,
  input  wire logic   csN,
  input  wire logic   dataIn,
  output logic        dataOut,
  output logic        dataOutEn,
  // guard pin / data lane 2
  input  wire logic   guardLane2In,
  output logic        guardLane2Out,
  output logic        guardLane2En,
  // pause pin / data lane 3
  input  wire logic   pauseLane3In,
  output logic        pauseLane3Out,
  output logic        pauseLane3En,
  // core side results
  output logic [7:0]  statusWord,
  output logic        quadMode,
  output fswg_arr_op_t arrOp
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  localparam int TMR_MAX = (1 << TMR_W) - 1;

  if (PROG_CYCLES < 1 || PROG_CYCLES > TMR_MAX) begin : g_chk_prog
    $error("PROG_CYCLES out of range");
  end
  if (ERASE_CYCLES < 1 || ERASE_CYCLES > TMR_MAX) begin : g_chk_erase
    $error("ERASE_CYCLES out of range");
  end
  if (CHIP_CYCLES < 1 || CHIP_CYCLES > TMR_MAX) begin : g_chk_chip
    $error("CHIP_CYCLES out of range");
  end
  if (REG_CYCLES < 1 || REG_CYCLES > TMR_MAX) begin : g_chk_reg
    $error("REG_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain: serial capture on sclk

  logic        frameRstN;
  logic        firstEdge_q;
  logic        frameTog_q;
  logic [6:0]  shift_q;
  logic [5:0]  bitCnt_q;
  logic [7:0]  opcode_q;
  logic [23:0] addr_q;
  logic        readMode_q;
  logic [7:0]  txByte_q;
  logic [7:0]  linkStatus;
  logic        linkQuad;
  logic        holdActive;
  logic [5:0]  nextCnt;
  logic [7:0]  curByte;
  logic        byteEnd;
  logic        addrByte;

  // deselect ends the frame; sclk may stop, so frame state resets off csN
  assign frameRstN  = arst_n & ~csN;
  assign linkQuad   = linkStatus[QUAD_BIT];
  assign holdActive = ~linkQuad & ~pauseLane3In;
  assign curByte    = {shift_q, dataIn};
  assign nextCnt    = firstEdge_q ? 6'h01 :
                      (bitCnt_q == LEN_MAX) ? bitCnt_q : bitCnt_q + 6'h01;
  assign byteEnd    = (nextCnt[2:0] == 3'h0);
  assign addrByte   = byteEnd && nextCnt >= LEN_REGWR && nextCnt <= LEN_ADDR;

  // status bits cross one by one; a read may mix bits from two adjacent
  // core cycles, acceptable for a polled flag
  fswg_sync #(.WIDTH(8), .RST_VAL(STATUS_RST)) u_syncStatus (
    .clk    (sclk),
    .rstN   (arst_n),
    .ce     (1'b1),
    .async  (statusWord),
    .synced (linkStatus)
  );

  always_ff @(posedge sclk or negedge frameRstN) begin
    if (!frameRstN) begin
      firstEdge_q <= 1'b1;
    end else if (!holdActive) begin
      firstEdge_q <= 1'b0;
    end
  end

  always_ff @(posedge sclk or negedge frameRstN) begin
    if (!frameRstN) begin
      readMode_q <= 1'b0;
    end else if (!holdActive && nextCnt == LEN_OPCODE && curByte == STATUS_READ_CMD) begin
      readMode_q <= 1'b1;
    end
  end

  // capture registers survive deselect so the core can read them afterwards
  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      frameTog_q <= 1'b0;
      shift_q    <= 7'h00;
      bitCnt_q   <= 6'h00;
      opcode_q   <= 8'h00;
      addr_q     <= 24'h000000;
      txByte_q   <= STATUS_RST;
    end else if (!holdActive) begin
      frameTog_q <= frameTog_q ^ firstEdge_q;
      shift_q    <= curByte[6:0];
      bitCnt_q   <= nextCnt;
      if (nextCnt == LEN_OPCODE) begin
        opcode_q <= curByte;
      end
      if (addrByte) begin
        addr_q <= {addr_q[15:0], curByte};
      end
      if (byteEnd) begin
        txByte_q <= linkStatus;
      end
    end
  end

  // output shifts on the falling edge, msb first, repeating each byte
  always_ff @(negedge sclk or negedge frameRstN) begin
    if (!frameRstN) begin
      dataOut   <= 1'b0;
      dataOutEn <= 1'b0;
    end else begin
      dataOut   <= txByte_q[3'h7 - bitCnt_q[2:0]];
      dataOutEn <= readMode_q & ~holdActive;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core domain: frame end detection

  logic [2:0]  coreSync;
  logic        csSync;
  logic        guardSync;
  logic        togSync;
  logic        csPrev_q;
  logic        togSeen_q;
  logic        frameValid;

  fswg_sync #(.WIDTH(3), .RST_VAL(3'h6)) u_syncCore (
    .clk    (core_clk),
    .rstN   (arst_n),
    .ce     (clkEn),
    .async  ({csN, guardLane2In, frameTog_q}),
    .synced (coreSync)
  );

  assign csSync     = coreSync[2];
  assign guardSync  = coreSync[1];
  assign togSync    = coreSync[0];
  // capture regs are stable once deselect is seen, so they are read directly
  assign frameValid = csSync & ~csPrev_q & (togSync != togSeen_q);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      csPrev_q  <= 1'b1;
      togSeen_q <= 1'b0;
    end else if (clkEn) begin
      csPrev_q  <= csSync;
      // advance only at frame end, else the toggle is absorbed mid-frame
      if (csSync && !csPrev_q) begin
        togSeen_q <= togSync;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core domain: instruction decode

  typedef enum logic {ST_IDLE, ST_BUSY} fswg_state_t;

  fswg_state_t state_q;
  logic [TMR_W-1:0] timer_q;
  logic        permit_q;
  logic [3:0]  guard_q;
  logic        quad_q;
  logic        lock_q;
  logic        lenOp;
  logic        lenReg;
  logic        lenAddr;
  logic        lenProg;
  logic        hitUnlock;
  logic        hitRelock;
  logic        hitStat;
  logic        hitFunc;
  logic        hitProg;
  logic        hitInfo;
  logic        hitSect;
  logic        hitHalf;
  logic        hitFull;
  logic        hitChip;
  logic        idle;
  logic        gateOpen;
  logic        statLocked;
  logic        startOp;
  logic        opDone;
  fswg_kind_t  kindSel;
  logic [TMR_W-1:0] cycSel;

  assign lenOp   = (bitCnt_q == LEN_OPCODE);
  assign lenReg  = (bitCnt_q == LEN_REGWR);
  assign lenAddr = (bitCnt_q == LEN_ADDR);
  assign lenProg = (bitCnt_q >= LEN_PROG) && (bitCnt_q[2:0] == 3'h0);

  assign hitUnlock = frameValid && lenOp && opcode_q == WRITE_UNLOCK_CMD;
  assign hitRelock = frameValid && lenOp && opcode_q == WRITE_RELOCK_CMD;
  assign hitStat   = lenReg && opcode_q == STATUS_WRITE_CMD;
  assign hitFunc   = lenReg && opcode_q == FUNCTION_WRITE_CMD;
  assign hitProg   = lenProg && (opcode_q == PAGE_PROGRAM_CMD ||
                                 opcode_q == QUAD_PAGE_PROGRAM_A ||
                                 opcode_q == QUAD_PAGE_PROGRAM_B);
  assign hitInfo   = lenProg && opcode_q == INFO_ROW_PROGRAM_CMD;
  assign hitSect   = lenAddr && (opcode_q == SECTOR_ERASE_A ||
                                 opcode_q == SECTOR_ERASE_B);
  assign hitHalf   = lenAddr && opcode_q == HALF_BLOCK_ERASE_CMD;
  assign hitFull   = lenAddr && opcode_q == FULL_BLOCK_ERASE_CMD;
  assign hitChip   = lenOp && (opcode_q == WHOLE_ARRAY_ERASE_A ||
                               opcode_q == WHOLE_ARRAY_ERASE_B);

  assign idle     = (state_q == ST_IDLE);
  assign gateOpen = frameValid && idle && permit_q;
  // guard pin only protects while it is not a data lane
  assign statLocked = lock_q && !guardSync && !quad_q;

  assign kindSel = hitProg ? OP_PROG :
                   hitInfo ? OP_INFO :
                   hitSect ? OP_SECT :
                   hitHalf ? OP_HALF :
                   hitFull ? OP_FULL :
                   (hitChip && guard_q == 4'h0) ? OP_CHIP :
                   (hitStat && !statLocked) ? OP_STAT :
                   hitFunc ? OP_FUNC : OP_NONE;

  assign cycSel = (kindSel == OP_PROG || kindSel == OP_INFO) ? TMR_W'(PROG_CYCLES) :
                  (kindSel == OP_CHIP) ? TMR_W'(CHIP_CYCLES) :
                  (kindSel == OP_STAT || kindSel == OP_FUNC) ? TMR_W'(REG_CYCLES) :
                  TMR_W'(ERASE_CYCLES);

  assign startOp = gateOpen && kindSel != OP_NONE;
  assign opDone  = !idle && timer_q == TMR_W'(1);

  ////////////////////////////////////////////////////////////////////////////
  // core domain: busy sequencer and permit latch

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      timer_q <= '0;
    end else if (clkEn) begin
      case (state_q)
        ST_IDLE: begin
          if (startOp) begin
            state_q <= ST_BUSY;
            timer_q <= cycSel;
          end
        end
        ST_BUSY: begin
          timer_q <= timer_q - TMR_W'(1);
          if (opDone) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // unlock is taken only when idle, so it can never meet the end-of-op clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      permit_q <= 1'b0;
    end else if (clkEn) begin
      if (hitUnlock && idle) begin
        permit_q <= 1'b1;
      end else if (hitRelock || opDone) begin
        permit_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core domain: non-volatile cells, modelled as reset to factory state

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      guard_q <= STATUS_RST[GUARD_MSB:GUARD_LSB];
      quad_q  <= STATUS_RST[QUAD_BIT];
      lock_q  <= STATUS_RST[LOCK_BIT];
    end else if (clkEn && startOp && kindSel == OP_STAT) begin
      guard_q <= addr_q[GUARD_MSB:GUARD_LSB];
      quad_q  <= addr_q[QUAD_BIT];
      lock_q  <= addr_q[LOCK_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core domain: registered outputs

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      statusWord <= STATUS_RST;
      quadMode   <= 1'b0;
      arrOp      <= '0;
    end else if (clkEn) begin
      statusWord <= {lock_q, quad_q, guard_q, permit_q, !idle};
      quadMode   <= quad_q;
      arrOp.valid     <= startOp;
      arrOp.kind      <= startOp ? kindSel : OP_NONE;
      arrOp.addr      <= addr_q;
      arrOp.sector    <= addr_q[ADDR_W-1:SECTOR_LSB];
      arrOp.halfBlock <= addr_q[ADDR_W-1:HALF_LSB];
      arrOp.block     <= addr_q[ADDR_W-1:BLOCK_LSB];
    end
  end

  // quad data transfer lives elsewhere; lanes 2 and 3 are never driven here
  logic laneIdle_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      laneIdle_q <= 1'b0;
    end else if (clkEn) begin
      laneIdle_q <= 1'b0;
    end
  end

  assign guardLane2Out = laneIdle_q;
  assign guardLane2En  = laneIdle_q;
  assign pauseLane3Out = laneIdle_q;
  assign pauseLane3En  = laneIdle_q;

endmodule : fswg_top
`default_nettype wire

// ===== verification/fswg_monitor.sv
// concurrent checks on the status and write-gate block ports
`timescale 1ns/1ps
`default_nettype none
module fswg_monitor
  import fswg_pkg::*;
#(
  parameter int PROG_CYCLES  = PROG_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter int CHIP_CYCLES  = CHIP_CYC,
  parameter int REG_CYCLES   = REG_CYC
) (
  // core clock and reset
  input wire logic         core_clk,
  input wire logic         arst_n,
  // link
  input wire logic         dataOutEn,
  // results
  input wire logic [7:0]   statusWord,
  input wire logic         quadMode,
  input wire fswg_arr_op_t arrOp
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////
  // busy length per operation kind, measured rather than predicted
  int         busyLen_q;
  int         expLen;
  fswg_kind_t kind_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busyLen_q <= 0;
      kind_q    <= OP_NONE;
    end else begin
      busyLen_q <= statusWord[BUSY_BIT] ? busyLen_q + 1 : 0;
      if (arrOp.valid) kind_q <= arrOp.kind;
    end
  end
  assign expLen = (kind_q == OP_CHIP) ? CHIP_CYCLES :
                  (kind_q inside {OP_STAT, OP_FUNC}) ? REG_CYCLES :
                  (kind_q inside {OP_PROG, OP_INFO}) ? PROG_CYCLES : ERASE_CYCLES;

  ////////////////////////////////////////////////////////////////////////
  a_gate_permit: assert property (arrOp.valid |->
    $past(statusWord[PERMIT_BIT]) && !$past(statusWord[BUSY_BIT]))
    else $error("op started without permit or while busy");
  a_op_busy: assert property (arrOp.valid |=> statusWord[BUSY_BIT] && !arrOp.valid)
    else $error("op start not a busy one-cycle pulse");
  a_sector_map: assert property (arrOp.valid |-> arrOp.sector == arrOp.addr[23:12]
    && arrOp.halfBlock == arrOp.addr[23:15]) else $error("sector or half block index wrong");
  a_block_map: assert property (arrOp.valid |-> arrOp.block == arrOp.addr[23:16])
    else $error("block index wrong");
  a_kind_idle: assert property (!arrOp.valid |-> arrOp.kind == OP_NONE)
    else $error("kind set without valid");
  a_busy_length: assert property ($fell(statusWord[BUSY_BIT]) |-> busyLen_q == expLen)
    else $error("busy length wrong for op kind");
  a_permit_auto: assert property ($fell(statusWord[BUSY_BIT]) |-> !statusWord[PERMIT_BIT])
    else $error("permit left set after op");
  a_chip_unguard: assert property (arrOp.valid && arrOp.kind == OP_CHIP |->
    statusWord[GUARD_MSB:GUARD_LSB] == 4'h0) else $error("chip erase with guard set");
  a_guard_source: assert property ($changed(statusWord[7:2]) |->
    arrOp.kind == OP_STAT || $past(arrOp.kind) == OP_STAT)
    else $error("guard bits changed without status write");
  a_quad_follow: assert property ($changed(statusWord[QUAD_BIT]) |->
    ##[0:1] quadMode == statusWord[QUAD_BIT]) else $error("quad mode not following");

  c_sector_op: cover property (arrOp.valid && arrOp.kind == OP_SECT);
  c_status_wr: cover property (arrOp.valid && arrOp.kind == OP_STAT);
  c_busy_done: cover property ($fell(statusWord[BUSY_BIT]));
  c_read_out: cover property ($rose(dataOutEn));
endmodule : fswg_monitor
`default_nettype wire

// ===== verification/fswg_host.sv
// serial host model: mode 0 frames, msb first, clock still between frames
`timescale 1ns/1ps
`default_nettype none
module fswg_host (
  // link pins
  output logic      sclk,
  output logic      csN,
  output logic      dataIn,
  output logic      pauseLane3In,
  input  wire logic dataOut
);
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    dataIn = 1'b1;
    pauseLane3In = 1'b1;
  end

  // bits are right aligned, the first sent is bits[n-1]
  task automatic xfer(input logic [39:0] bits, input int n, output logic [7:0] rd);
    rd = 8'h00;
    #7;
    csN = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      dataIn = bits[i];
      #24 sclk = 1'b1;
      rd = {rd[6:0], dataOut};
      #24 sclk = 1'b0;
    end
    #24 csN = 1'b1;
    // released line must not keep showing the last bit
    dataIn = ~dataIn;
  endtask : xfer
endmodule : fswg_host
`default_nettype wire

// ===== verification/tb_flash_status_write_gate.sv
// self-checking bench for the status and write-gate block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb_flash_status_write_gate;
  import fswg_pkg::*;
  localparam int PC = 12, EC = 16, CC = 60, RC = 10;
  logic         core_clk, arst_n, clkEn, guardLane2In;
  logic         sclk, csN, dataIn, pauseLane3In, dataOut, dataOutEn, quadMode;
  logic [7:0]   statusWord;
  fswg_arr_op_t arrOp;
  wire [3:0]    laneOut;
  int           err_total, samples_checked;
  logic [5:0]   nv;
  logic         permM;
  logic [7:0]   code [12] = '{PAGE_PROGRAM_CMD, QUAD_PAGE_PROGRAM_A, QUAD_PAGE_PROGRAM_B,
    INFO_ROW_PROGRAM_CMD, SECTOR_ERASE_A, SECTOR_ERASE_B, HALF_BLOCK_ERASE_CMD,
    FULL_BLOCK_ERASE_CMD, WHOLE_ARRAY_ERASE_A, WHOLE_ARRAY_ERASE_B, STATUS_WRITE_CMD,
    FUNCTION_WRITE_CMD};
  fswg_kind_t   kd [12] = '{OP_PROG, OP_PROG, OP_PROG, OP_INFO, OP_SECT, OP_SECT,
    OP_HALF, OP_FULL, OP_CHIP, OP_CHIP, OP_STAT, OP_FUNC};
  int           ln [12] = '{40, 40, 40, 40, 32, 32, 32, 32, 8, 8, 16, 16};

  fswg_host u_host (.sclk(sclk), .csN(csN), .dataIn(dataIn),
    .pauseLane3In(pauseLane3In), .dataOut(dataOut));
  fswg_top #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC), .CHIP_CYCLES(CC), .REG_CYCLES(RC)) dut (
    .core_clk(core_clk), .arst_n(arst_n), .clkEn(clkEn), .sclk(sclk), .csN(csN),
    .dataIn(dataIn), .dataOut(dataOut), .dataOutEn(dataOutEn),
    .guardLane2In(guardLane2In), .guardLane2Out(laneOut[0]), .guardLane2En(laneOut[1]),
    .pauseLane3In(pauseLane3In), .pauseLane3Out(laneOut[2]), .pauseLane3En(laneOut[3]),
    .statusWord(statusWord), .quadMode(quadMode), .arrOp(arrOp));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task final_report;
    if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // keeps at least four core cycles between frame ends
  task automatic cmd8(input logic [7:0] c);
    logic [7:0] rd;
    u_host.xfer({32'h0, c}, 8, rd);
    repeat (6) @(posedge core_clk);
  endtask : cmd8

  task automatic rd_chk(input logic [7:0] e);
    logic [7:0] rd;
    u_host.xfer({24'h0, STATUS_READ_CMD, 8'h00}, 16, rd);
    repeat (6) @(posedge core_clk);
    #1;
    `CHK(rd, e)
    `CHK(statusWord, e)
  endtask : rd_chk

  task automatic run_op(input int k, input logic [7:0] wdata);
    logic [23:0] addr;
    logic [7:0]  rd;
    logic        ok;
    logic        seen;
    int          t;
    addr = (ln[k] == 16) ? {wdata, 16'h0000} : 24'($urandom);
    ok = permM && !(kd[k] == OP_CHIP && nv[3:0] != 4'h0)
      && !(kd[k] == OP_STAT && nv[5] && !guardLane2In && !nv[4]);
    u_host.xfer({code[k], addr, wdata} >> (40 - ln[k]), ln[k], rd);
    seen = 1'b0;
    for (t = 0; t < 8 && !seen; t++) begin
      @(posedge core_clk);
      #1;
      seen = (arrOp.valid === 1'b1);
    end
    `CHK(seen, ok)
    if (seen) `CHK(arrOp.kind, kd[k])
    if (seen && ln[k] >= 32) `CHK(arrOp.block, addr[23:16])
    if (ok && kd[k] == OP_STAT) nv = wdata[7:2];
    if (ok && kd[k] == OP_CHIP) rd_chk({nv, 2'b11});
    t = 0;
    // poll busy before anything further is sent; busy shows one cycle after start
    @(posedge core_clk);
    #1;
    while (statusWord[BUSY_BIT] !== 1'b0 && t < 2000) begin
      @(posedge core_clk);
      #1;
      t++;
    end
    `CHK(statusWord[BUSY_BIT], 1'b0)
    if (ok) permM = 1'b0;
    rd_chk({nv, permM, 1'b0});
  endtask : run_op

  ////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    clkEn = 1'b1;
    guardLane2In = 1'b1;
    err_total = 0;
    samples_checked = 0;
    nv = '0;
    permM = 1'b0;
    void'($urandom(32'h1ec2));
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd_chk(8'h00);
    run_op(4, 8'h00);
    cmd8(WRITE_UNLOCK_CMD);
    permM = 1'b1;
    rd_chk(8'h02);
    cmd8(WRITE_RELOCK_CMD);
    permM = 1'b0;
    rd_chk(8'h00);
    // every gated code, each after its own unlock
    for (int k = 0; k < 12; k++) begin
      cmd8(WRITE_UNLOCK_CMD);
      permM = 1'b1;
      run_op(k, 8'($urandom) & 8'hbc);
    end
    cmd8(WRITE_UNLOCK_CMD);
    permM = 1'b1;
    run_op(10, 8'hbc);
    cmd8(WRITE_UNLOCK_CMD);
    permM = 1'b1;
    run_op(8, 8'h00);
    @(posedge core_clk) guardLane2In <= 1'b0;
    repeat (4) @(posedge core_clk);
    run_op(10, 8'h00);
    @(posedge core_clk) guardLane2In <= 1'b1;
    repeat (4) @(posedge core_clk);
    run_op(10, 8'h40);
    `CHK(quadMode, 1'b1)
    `CHK(laneOut, 4'h0)
    final_report();
  end

  initial begin
    #1000000;
    err_total++;
    final_report();
  end
endmodule : tb_flash_status_write_gate

bind fswg_top fswg_monitor #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES),
  .CHIP_CYCLES(CHIP_CYCLES), .REG_CYCLES(REG_CYCLES)) u_mon (.core_clk(core_clk),
  .arst_n(arst_n), .dataOutEn(dataOutEn), .statusWord(statusWord), .quadMode(quadMode),
  .arrOp(arrOp));
`default_nettype wire
